// ### hdl/coil_decode.sv
// Access class decoder for the coil offsets
`timescale 1ns/10ps
`default_nettype none

module coil_decode
   import coil_map_pkg::*;
(
   coil_if.decoder dec
);

   // ------------------------------------------------------------------
   // Classification
   // ------------------------------------------------------------------
   // Unused, reserved and unlisted offsets fall through to neither class
   always_comb
   begin
      dec.rw_hit = 1'b0;
      dec.ro_hit = 1'b0;
      if ((dec.addr >= COIL_RUN) && (dec.addr <= COIL_FAULT_CLEAR))
         dec.rw_hit = 1'b1;
      else if ((dec.addr >= COIL_TERM_FIRST) &&
               (dec.addr < COIL_TERM_FIRST + 16'(NUM_TERMINALS)))
         dec.rw_hit = 1'b1;
      else if ((dec.addr == COIL_DIR_STATUS) || (dec.addr == COIL_RUNNING))
         dec.ro_hit = 1'b1;
   end

endmodule : coil_decode

`default_nettype wire

// ### hdl/coil_if.sv
// Decode carrier between the coil map core and its address decoder
`timescale 1ns/10ps
`default_nettype none

interface coil_if;
   import coil_map_pkg::*;

   logic [ADDR_W-1:0] addr;    // Coil offset under access
   logic              rw_hit;  // Offset names a read-write coil
   logic              ro_hit;  // Offset names a read-only status coil

   modport core    (output addr, input  rw_hit, input ro_hit);
   modport decoder (input  addr, output rw_hit, output ro_hit);

endinterface : coil_if

`default_nettype wire

// ### hdl/coil_map_pkg.sv
// Constants shared by the network coil map: coil offsets, widths and reset values
`default_nettype none

package coil_map_pkg;

   // ------------------------------------------------------------------
   // Coil address space
   // ------------------------------------------------------------------
   localparam int          ADDR_W           = 16;
   localparam logic [15:0] COIL_UNUSED      = 16'h0000;
   localparam logic [15:0] COIL_RUN         = 16'h0001;
   localparam logic [15:0] COIL_DIR         = 16'h0002;
   localparam logic [15:0] COIL_EXT_FAULT   = 16'h0003;
   localparam logic [15:0] COIL_FAULT_CLEAR = 16'h0004;
   localparam logic [15:0] COIL_RSVD_A      = 16'h0005;
   localparam logic [15:0] COIL_RSVD_B      = 16'h0006;
   localparam logic [15:0] COIL_TERM_FIRST  = 16'h0007;
   localparam int          NUM_TERMINALS    = 7;
   localparam logic [15:0] COIL_DIR_STATUS  = 16'h0016;
   localparam logic [15:0] COIL_RUNNING     = 16'h0017;

   // ------------------------------------------------------------------
   // Run-command source selection
   // ------------------------------------------------------------------
   localparam int          SRC_W            = 2;
   localparam logic [1:0]  SRC_NETWORK      = 2'h3;

   // ------------------------------------------------------------------
   // Values after reset and access timing
   // ------------------------------------------------------------------
   localparam logic        COIL_RESET       = 1'b0;
   localparam int          ACK_CYCLES       = 1;

endpackage : coil_map_pkg

`default_nettype wire

// ### hdl/drive_network_coil_map.sv
// Network coil map of the drive controller: command, terminal and status coils
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Every coil is one bit, reached by its coil offset in the network coil space.
// - Only read-write coils take master writes; read-only status coils never change by them.
// - The run coil asks run on 1 and stop on 0, acting only while the run source equals 03.
// - The direction coil asks reverse on 1 and forward on 0, only while the source is 03.
// - Each input terminal coil reads back and writes; 1 asserts its function, 0 releases it.
// - The running status coil reads 1 while the drive runs and 0 when stopped.
// - The direction status coil reads 1 in reverse and 0 in forward, following the monitor.
module drive_network_coil_map
   import coil_map_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     coil_req,
   input  wire logic                     coil_we,
   input  wire logic [ADDR_W-1:0]        coil_addr,
   input  wire logic                     coil_wdata,
   output logic                          coil_rdata,
   output logic                          coil_ack,
   output logic                          coil_refused,
   input  wire logic [SRC_W-1:0]         run_command_source_select,
   input  wire logic                     drive_running,
   input  wire logic                     direction_monitor,
   output logic                          run_request,
   output logic                          reverse_request,
   output logic                          external_fault_input,
   output logic                          fault_clear_input,
   output logic [NUM_TERMINALS-1:0]      input_terminal
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                     run_coil;
      logic                     dir_coil;
      logic                     ext_coil;
      logic                     clr_coil;
      logic [NUM_TERMINALS-1:0] term;
      logic                     rdata;
      logic                     ack;
      logic                     refused;
      logic                     run_req;
      logic                     rev_req;
      logic                     clr_pulse;
   } coil_state_s;

   localparam coil_state_s STATE_RESET = '{
      run_coil  : COIL_RESET,
      dir_coil  : COIL_RESET,
      ext_coil  : COIL_RESET,
      clr_coil  : COIL_RESET,
      term      : {NUM_TERMINALS{COIL_RESET}},
      rdata     : 1'b0,
      ack       : 1'b0,
      refused   : 1'b0,
      run_req   : 1'b0,
      rev_req   : 1'b0,
      clr_pulse : 1'b0
   };

   coil_state_s              st;
   coil_state_s              next_st;
   logic [NUM_TERMINALS-1:0] term_hit;
   logic                     wr_go;
   logic                     rd_go;
   logic                     net_src;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   coil_if u_dec_if ();

   assign u_dec_if.addr = coil_addr;

   coil_decode u_decode (
      .dec (u_dec_if.decoder)
   );

   // One compare per terminal coil, each at its own offset
   genvar gi;
   for (gi = 0; gi < NUM_TERMINALS; gi++)
   begin : g_term
      assign term_hit[gi] = (coil_addr == COIL_TERM_FIRST + 16'(gi));
   end

   // Writes only land on read-write coils; status and reserved offsets drop them
   assign wr_go   = coil_req & coil_we & u_dec_if.rw_hit;
   assign rd_go   = coil_req & ~coil_we;
   assign net_src = (run_command_source_select == SRC_NETWORK);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Commands are gated at the output, not at the coil, so a coil written
   // while another source owns the drive takes effect once 03 is selected.
   always_comb
   begin
      next_st           = st;
      next_st.ack       = coil_req;
      next_st.refused   = 1'b0;
      next_st.clr_pulse = 1'b0;

      // Coil writes, one bit each
      if (wr_go)
      begin
         if (coil_addr == COIL_RUN)
            next_st.run_coil = coil_wdata;
         if (coil_addr == COIL_DIR)
            next_st.dir_coil = coil_wdata;
         if (coil_addr == COIL_EXT_FAULT)
            next_st.ext_coil = coil_wdata;
         if (coil_addr == COIL_FAULT_CLEAR)
         begin
            next_st.clr_coil  = coil_wdata;
            next_st.clr_pulse = coil_wdata;
         end
      end

      // Terminal coils: set or clear only the addressed bit
      next_st.term = (st.term & ~({NUM_TERMINALS{wr_go}} & term_hit)) |
                     ({NUM_TERMINALS{wr_go & coil_wdata}} & term_hit);

      // Write to a status, reserved or unlisted offset is refused
      if (coil_req & coil_we & ~u_dec_if.rw_hit)
         next_st.refused = 1'b1;

      // Read data: stored coil, live status, or zero
      next_st.rdata = 1'b0;
      if (rd_go)
      begin
         if (coil_addr == COIL_RUN)
            next_st.rdata = st.run_coil;
         else if (coil_addr == COIL_DIR)
            next_st.rdata = st.dir_coil;
         else if (coil_addr == COIL_EXT_FAULT)
            next_st.rdata = st.ext_coil;
         else if (coil_addr == COIL_FAULT_CLEAR)
            next_st.rdata = st.clr_coil;
         else if (|term_hit)
            next_st.rdata = |(st.term & term_hit);
         else if (coil_addr == COIL_DIR_STATUS)
            next_st.rdata = direction_monitor;
         else if (coil_addr == COIL_RUNNING)
            next_st.rdata = drive_running;
         else
         begin
            next_st.rdata   = 1'b0;
            next_st.refused = 1'b1;
         end
      end

      // Command outputs follow the coils only under network control
      next_st.run_req = next_st.run_coil & net_src;
      next_st.rev_req = next_st.dir_coil & net_src;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         st <= STATE_RESET;
      else
         st <= next_st;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // All data outputs come straight from the state register
   assign coil_rdata           = st.rdata;
   assign coil_ack             = st.ack;
   assign coil_refused         = st.refused;
   assign run_request          = st.run_req;
   assign reverse_request      = st.rev_req;
   assign external_fault_input = st.ext_coil;
   assign fault_clear_input    = st.clr_pulse;
   assign input_terminal       = st.term;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!rst_n);

   // Every access is answered exactly one cycle later
   chk_ack_one_cycle: assert property (
      coil_req |=> coil_ack)
      else $error("access not acknowledged after one cycle");

   // A write to the running status coil is refused and leaves the terminal and external fault outputs alone
   chk_ro_write_ignored: assert property (
      (coil_req && coil_we && (coil_addr == COIL_RUNNING))
      |=> coil_refused && $stable(input_terminal) && $stable(external_fault_input))
      else $error("write to status coil altered drive state");

   // Run coil set under network control raises the run request next cycle
   chk_run_network: assert property (
      (coil_req && coil_we && (coil_addr == COIL_RUN) && coil_wdata &&
       (run_command_source_select == SRC_NETWORK))
      |=> run_request)
      else $error("run request missing after run coil write");

   // Run request never stands unless the source was the network
   chk_run_gated: assert property (
      (run_command_source_select != SRC_NETWORK) |=> !run_request)
      else $error("run request raised under a foreign source");

   // Reverse request only when the source was the network in the cycle before
   chk_dir_gated: assert property (
      reverse_request |-> ($past(run_command_source_select) == SRC_NETWORK))
      else $error("reverse request raised under a foreign source");

   // A read of the first terminal coil returns the level driven on terminal 0
   chk_term_roundtrip: assert property (
      (coil_req && !coil_we && (coil_addr == COIL_TERM_FIRST))
      |=> coil_rdata == $past(input_terminal[0]))
      else $error("terminal coil read back wrong");

   // Running status read returns the running level at the read
   chk_running_read: assert property (
      (coil_req && !coil_we && (coil_addr == COIL_RUNNING))
      |=> (coil_rdata == $past(drive_running)) && !coil_refused)
      else $error("running status read mismatch");

   // Direction status read returns the monitor at the read
   chk_dir_read: assert property (
      (coil_req && !coil_we && (coil_addr == COIL_DIR_STATUS))
      |=> coil_rdata == $past(direction_monitor))
      else $error("direction status read mismatch");

   // Reserved offset 0005 and unused offset 0000 read as zero and are flagged
   chk_rsvd_zero: assert property (
      (coil_req && !coil_we &&
       ((coil_addr == COIL_RSVD_A) || (coil_addr == COIL_UNUSED)))
      |=> !coil_rdata && coil_refused)
      else $error("reserved coil read not zero");

   // Fault clear is a single-cycle pulse unless another clear write follows at once
   chk_clear_pulse: assert property (
      fault_clear_input &&
      !(coil_req && coil_we && (coil_addr == COIL_FAULT_CLEAR) && coil_wdata)
      |=> !fault_clear_input)
      else $error("fault clear pulse longer than one cycle");

   // An idle cycle is never answered, so each request gets exactly one answer
   chk_ack_idle: assert property (
      !coil_req |=> !coil_ack)
      else $error("answer without a request");

   // Read data stays low unless a read is being answered
   chk_rdata_idle: assert property (
      !(coil_req && !coil_we) |=> !coil_rdata)
      else $error("read data high without a read");

   // Writes to the command and fault coils are accepted
   chk_rw_accepted: assert property (
      (coil_req && coil_we && (coil_addr >= COIL_RUN) && (coil_addr <= COIL_FAULT_CLEAR))
      |=> !coil_refused)
      else $error("write to a read-write coil refused");

   // The external fault output takes the written coil value
   chk_ext_follows: assert property (
      (coil_req && coil_we && (coil_addr == COIL_EXT_FAULT))
      |=> external_fault_input == $past(coil_wdata))
      else $error("external fault output not the written value");

   // Direction coil set under network control raises the reverse request
   chk_rev_network: assert property (
      (coil_req && coil_we && (coil_addr == COIL_DIR) && coil_wdata &&
       (run_command_source_select == SRC_NETWORK))
      |=> reverse_request)
      else $error("reverse request missing after direction coil write");

   // A write to the first terminal coil drives terminal 0 to the written value
   chk_term_set: assert property (
      (coil_req && coil_we && (coil_addr == COIL_TERM_FIRST))
      |=> input_terminal[0] == $past(coil_wdata))
      else $error("terminal not driven to the written value");

   // A write to a reserved offset is refused and leaves the drive alone
   chk_rsvd_write: assert property (
      (coil_req && coil_we && ((coil_addr == COIL_RSVD_A) || (coil_addr == COIL_RSVD_B)))
      |=> coil_refused && $stable(input_terminal) && $stable(external_fault_input))
      else $error("write to reserved coil took effect");

   cov_run_write: cover property (
      coil_req && coil_we && (coil_addr == COIL_RUN) && coil_wdata ##1 run_request);

   cov_term_write: cover property (
      coil_req && coil_we && term_hit[NUM_TERMINALS-1] && coil_wdata);

   cov_refused_write: cover property (
      coil_req && coil_we && (coil_addr == COIL_DIR_STATUS) ##1 coil_refused);

   cov_fault_clear: cover property (fault_clear_input);

   // Run request standing while the source was not the network in the cycle before
   cov_source_back: cover property (
      run_request && $past(run_command_source_select != SRC_NETWORK));

endmodule : drive_network_coil_map

`default_nettype wire

// ### tb/drive_network_coil_map_bench.sv
// Self-checking testbench of the drive network coil map
`timescale 1ns/10ps
`default_nettype none

module drive_network_coil_map_bench
   import coil_map_pkg::*;
;
   logic                     sys_clk;
   logic                     rst_n;
   logic                     coil_req;
   logic                     coil_we;
   logic [ADDR_W-1:0]        coil_addr;
   logic                     coil_wdata;
   logic                     coil_rdata;
   logic                     coil_ack;
   logic                     coil_refused;
   logic [SRC_W-1:0]         src;
   logic                     drive_running;
   logic                     direction_monitor;
   logic                     run_request;
   logic                     reverse_request;
   logic                     ext_fault;
   logic                     fault_clear;
   logic [NUM_TERMINALS-1:0] input_terminal;
   int                       n_fail;
   int                       num_checks;

   // ------------------------------------------------------------------
   // Clock, design and master
   // ------------------------------------------------------------------
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   drive_network_coil_map uut (.sys_clk(sys_clk), .rst_n(rst_n), .coil_req(coil_req),
      .coil_we(coil_we), .coil_addr(coil_addr), .coil_wdata(coil_wdata),
      .coil_rdata(coil_rdata), .coil_ack(coil_ack), .coil_refused(coil_refused),
      .run_command_source_select(src), .drive_running(drive_running),
      .direction_monitor(direction_monitor), .run_request(run_request),
      .reverse_request(reverse_request), .external_fault_input(ext_fault),
      .fault_clear_input(fault_clear), .input_terminal(input_terminal));

   network_master_model master (.sys_clk(sys_clk), .coil_req(coil_req), .coil_we(coil_we),
      .coil_addr(coil_addr), .coil_wdata(coil_wdata), .coil_rdata(coil_rdata),
      .coil_ack(coil_ack), .coil_refused(coil_refused));

   // ------------------------------------------------------------------
   // Shared comparison and access tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [6:0] seen, input logic [6:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: saw %b, expected %b", $time, seen, exp);
      end
   endtask : check

   // Odd offsets are requested after a pause, so slow masters are covered too
   task automatic acc(input logic we, input logic [15:0] a, input logic d,
                      input logic exp_ref, input logic exp_rd);
      logic rd;
      logic rf;
      logic ak;
      master.access(we, a, d, 3 * int'(a[0]), rd, rf, ak);
      check(7'(ak), 7'h01);
      check(7'(rf), 7'(exp_ref));
      check(7'(rd), 7'(exp_rd));
   endtask : acc

   task automatic outs_zero();
      check({run_request, reverse_request, ext_fault, fault_clear, 3'h0}, 7'h00);
      check(input_terminal, 7'h00);
   endtask : outs_zero

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_run_dir();
      acc(1'b1, COIL_RUN, 1'b1, 1'b0, 1'b0);
      check(7'(run_request), 7'h01);
      acc(1'b1, COIL_DIR, 1'b1, 1'b0, 1'b0);
      check(7'(reverse_request), 7'h01);
      src = 2'h1;
      @(posedge sys_clk);
      #1;
      check(7'(run_request), 7'h00);
      check(7'(reverse_request), 7'h00);
      acc(1'b0, COIL_RUN, 1'b0, 1'b0, 1'b1);
      src = 2'h3;
      @(posedge sys_clk);
      #1;
      check(7'(run_request), 7'h01);
      acc(1'b1, COIL_RUN, 1'b0, 1'b0, 1'b0);
      acc(1'b1, COIL_DIR, 1'b0, 1'b0, 1'b0);
      outs_zero();
   endtask : t_run_dir

   task automatic t_fault();
      acc(1'b1, COIL_EXT_FAULT, 1'b1, 1'b0, 1'b0);
      check(7'(ext_fault), 7'h01);
      acc(1'b1, COIL_FAULT_CLEAR, 1'b1, 1'b0, 1'b0);
      check(7'(fault_clear), 7'h01);
      @(posedge sys_clk);
      #1;
      check(7'(fault_clear), 7'h00);
      acc(1'b1, COIL_EXT_FAULT, 1'b0, 1'b0, 1'b0);
      check(7'(ext_fault), 7'h00);
   endtask : t_fault

   task automatic t_terminals();
      for (int i = 0; i < NUM_TERMINALS; i++)
      begin
         acc(1'b1, COIL_TERM_FIRST + 16'(i), 1'b1, 1'b0, 1'b0);
         check(input_terminal, 7'(1 << i));
         acc(1'b0, COIL_TERM_FIRST + 16'(i), 1'b0, 1'b0, 1'b1);
         acc(1'b1, COIL_TERM_FIRST + 16'(i), 1'b0, 1'b0, 1'b0);
         check(input_terminal, 7'h00);
      end
   endtask : t_terminals

   // Status coils follow the monitors; writes to the running status coil are refused and change nothing
   task automatic t_status();
      for (int k = 0; k < 4; k++)
      begin
         drive_running     = k[0];
         direction_monitor = k[1];
         acc(1'b0, COIL_RUNNING, 1'b0, 1'b0, k[0]);
         acc(1'b0, COIL_DIR_STATUS, 1'b0, 1'b0, k[1]);
         acc(1'b1, COIL_RUNNING, ~k[0], 1'b1, 1'b0);
         acc(1'b0, COIL_RUNNING, 1'b0, 1'b0, k[0]);
      end
   endtask : t_status

   task automatic t_reserved();
      logic [15:0] offs [7] = '{16'h0000, 16'h0005, 16'h0006, 16'h000e, 16'h0015,
                                16'h0018, 16'hffff};
      foreach (offs[i])
      begin
         acc(1'b1, offs[i], 1'b1, 1'b1, 1'b0);
         acc(1'b0, offs[i], 1'b0, 1'b1, 1'b0);
      end
      outs_zero();
   endtask : t_reserved

   // ------------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ------------------------------------------------------------------
   task automatic give_verdict();
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   // About 230 cycles are needed; the limit leaves a wide margin
   initial
   begin
      #50000;
      n_fail++;
      give_verdict();
   end

   initial
   begin
      n_fail            = 0;
      num_checks        = 0;
      rst_n             = 1'b0;
      src               = SRC_NETWORK;
      drive_running     = 1'b0;
      direction_monitor = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      outs_zero();
      t_run_dir();
      t_fault();
      t_terminals();
      t_status();
      t_reserved();
      give_verdict();
   end
endmodule : drive_network_coil_map_bench

`default_nettype wire

// ### tb/network_master_model.sv
// Behavioural network master that issues single coil accesses to the map
`timescale 1ns/10ps
`default_nettype none

module network_master_model
   import coil_map_pkg::*;
(
   input  wire logic              sys_clk,
   output logic                   coil_req,
   output logic                   coil_we,
   output logic [ADDR_W-1:0]      coil_addr,
   output logic                   coil_wdata,
   input  wire logic              coil_rdata,
   input  wire logic              coil_ack,
   input  wire logic              coil_refused
);
   // ------------------------------------------------------------------
   // Idle lines at time zero
   // ------------------------------------------------------------------
   initial
   begin
      coil_req   = 1'b0;
      coil_we    = 1'b0;
      coil_addr  = 16'h0000;
      coil_wdata = 1'b0;
   end

   // ------------------------------------------------------------------
   // One access: request for one edge, answer taken one cycle later
   // ------------------------------------------------------------------
   // A gap before the request models a slow master
   task automatic access(input logic we, input logic [ADDR_W-1:0] addr, input logic wdata,
                         input int gap, output logic rdata, output logic refused,
                         output logic ack);
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
      coil_req   = 1'b1;
      coil_we    = we;
      coil_addr  = addr;
      coil_wdata = wdata;
      @(posedge sys_clk);
      #1;
      // Released lines show the inverse, so a stale value cannot pass for a live one
      coil_req   = 1'b0;
      coil_we    = ~we;
      coil_addr  = ~addr;
      coil_wdata = ~wdata;
      ack        = coil_ack;
      rdata      = coil_rdata;
      refused    = coil_refused;
   endtask : access
endmodule : network_master_model

`default_nettype wire
